//--- lcdhbi_consts.vh
`ifndef LCDHBI_CONSTS_VH
`define LCDHBI_CONSTS_VH
`define LCDHBI_DATA_W 8
`define LCDHBI_BITCNT_W 3
`define LCDHBI_BITCNT_LAST 3'h7
`define LCDHBI_FIFO_DEPTH 8
`define LCDHBI_FIFO_AW 3
`define LCDHBI_DATA_RST 8'h00
`define LCDHBI_BUS_IDLE 8'hFF
`endif

//--- lcdhbi_fifo.v
`timescale 1ns/1ps
module lcdhbi_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset.
   input wire clk_in,
   input wire rst_n_in,
   // Fill side.
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   // Drain side.
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_q;
   reg [AW:0] rd_q;
   wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire empty = (wr_q == rd_q);
   wire push = in_valid_in && !full;
   wire pop = out_valid_out && out_ready_in;
   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = mem[rd_q[AW-1:0]];
   always @(posedge clk_in) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data_in;
      end
   end
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule // lcdhbi_fifo

//--- lcdhbi_host_if.v
`timescale 1ns/1ps
`include "lcdhbi_consts.vh"
// Function
// - Strap high parallel bus, low serial
// - Serial: data on pin 7, clock pin 6
// - Serial mode never drives read data
// - Bus strap picks 68 or 80 style
// - Classify access from select and direction
// - Select high: display data read/write
// - Select low: status read, instruction write
// - Deselected: float pins, ignore inputs
// - Serial MSB first, byte on eighth edge
// - Deselect resets shift register and counter
module lcdhbi_host_if (
   // Clock and reset.
   input wire clk_in,
   input wire rst_n_in,
   // Straps.
   input wire parallel_strap_in,
   input wire bus_style_strap_in,
   // Host pins.
   input wire chip_select_n_in,
   input wire data_command_select_in,
   input wire rd_pin_in,
   input wire wr_pin_in,
   input wire [7:0] data_pins_in,
   output reg [7:0] data_pins_out,
   output reg [7:0] data_pins_oe_n_out,
   // Read data from the core.
   input wire [7:0] disp_rd_data_in,
   input wire [7:0] status_in,
   // Received bytes: rx_is_display_out high for display data, low for instruction.
   output reg rx_valid_out,
   input wire rx_ready_in,
   output reg [7:0] rx_data_out,
   output reg rx_is_display_out,
   output reg disp_rd_pulse_out,
   output reg overflow_out
);
   // Three-stage samplers; stage 1 feeds stage 2 only.
   reg [2:0] cs_s_q;
   reg [2:0] dc_s_q;
   reg [2:0] rd_s_q;
   reg [2:0] wr_s_q;
   reg [2:0] d7_s_q;
   reg [2:0] d6_s_q;
   reg [2:0] ps_s_q;
   reg [2:0] st_s_q;
   reg [7:0] db_s1_q;
   reg [7:0] db_s2_q;
   reg [7:0] db_s3_q;
   reg cs_q;
   reg dc_q;
   reg rd_q;
   reg wr_q;
   reg d7_q;
   reg d6_q;
   reg ps_q;
   reg st_q;
   reg dir_q;
   reg [7:0] db_q;
   reg acc_q;
   reg [7:0] shift_q;
   reg [2:0] bitcnt_q;
   reg fifo_v_q;
   reg [8:0] fifo_d_q;
   wire fifo_rdy;
   wire fifo_ov;
   wire [8:0] fifo_od;
   // Samplers rest at the idle pin levels so that no false edge follows reset.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         cs_s_q <= 3'h7;
         dc_s_q <= 3'h0;
         rd_s_q <= 3'h7;
         wr_s_q <= 3'h7;
         d7_s_q <= 3'h0;
         d6_s_q <= 3'h0;
         ps_s_q <= 3'h0;
         st_s_q <= 3'h0;
         db_s1_q <= `LCDHBI_DATA_RST;
         db_s2_q <= `LCDHBI_DATA_RST;
         db_s3_q <= `LCDHBI_DATA_RST;
      end else begin
         cs_s_q <= {cs_s_q[1:0], chip_select_n_in};
         dc_s_q <= {dc_s_q[1:0], data_command_select_in};
         rd_s_q <= {rd_s_q[1:0], rd_pin_in};
         wr_s_q <= {wr_s_q[1:0], wr_pin_in};
         d7_s_q <= {d7_s_q[1:0], data_pins_in[7]};
         d6_s_q <= {d6_s_q[1:0], data_pins_in[6]};
         ps_s_q <= {ps_s_q[1:0], parallel_strap_in};
         st_s_q <= {st_s_q[1:0], bus_style_strap_in};
         db_s1_q <= data_pins_in;
         db_s2_q <= db_s1_q;
         db_s3_q <= db_s2_q;
      end
   end
   // A level is accepted once stages two and three agree.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         cs_q <= 1'b1;
         dc_q <= 1'b0;
         rd_q <= 1'b1;
         wr_q <= 1'b1;
         d7_q <= 1'b0;
         d6_q <= 1'b0;
         ps_q <= 1'b0;
         st_q <= 1'b0;
         db_q <= `LCDHBI_DATA_RST;
      end else begin
         if (cs_s_q[1] == cs_s_q[2]) cs_q <= cs_s_q[2];
         if (dc_s_q[1] == dc_s_q[2]) dc_q <= dc_s_q[2];
         if (rd_s_q[1] == rd_s_q[2]) rd_q <= rd_s_q[2];
         if (wr_s_q[1] == wr_s_q[2]) wr_q <= wr_s_q[2];
         if (d7_s_q[1] == d7_s_q[2]) d7_q <= d7_s_q[2];
         if (d6_s_q[1] == d6_s_q[2]) d6_q <= d6_s_q[2];
         if (ps_s_q[1] == ps_s_q[2]) ps_q <= ps_s_q[2];
         if (st_s_q[1] == st_s_q[2]) st_q <= st_s_q[2];
         // The data bus is filtered as one word.
         if (db_s2_q == db_s3_q) db_q <= db_s3_q;
      end
   end
   // Access decode per bus style.
   wire sel = !cs_q;
   wire par_act = st_q ? rd_q : (!rd_q || !wr_q);
   wire par_read = st_q ? wr_q : !rd_q;
   wire par_on = ps_q && sel && par_act;
   wire sclk_rise = !ps_q && sel && d6_s_q[1] && d6_s_q[2] && !d6_q;
   // Trailing edge of a parallel access, in the same cycle that the strobe is first seen to end.
   wire acc_end = acc_q && !par_on;
   // The output stage takes a new byte when it is empty or being emptied.
   wire rx_take = !rx_valid_out || rx_ready_in;
   // Direction follows the pins while the access runs and is held after it, because both bus styles drop
   // their direction qualifiers together with the strobe.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         dir_q <= 1'b0;
      end else if (par_on) begin
         dir_q <= par_read;
      end
   end
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         acc_q <= 1'b0;
         shift_q <= `LCDHBI_DATA_RST;
         bitcnt_q <= 3'h0;
         fifo_v_q <= 1'b0;
         fifo_d_q <= 9'h000;
         disp_rd_pulse_out <= 1'b0;
         data_pins_out <= `LCDHBI_DATA_RST;
         data_pins_oe_n_out <= `LCDHBI_BUS_IDLE;
         overflow_out <= 1'b0;
      end else begin
         acc_q <= par_on;
         fifo_v_q <= 1'b0;
         disp_rd_pulse_out <= 1'b0;
         // Byte completes at the trailing edge of the strobe.
         if (acc_end && !dir_q) begin
            fifo_v_q <= 1'b1;
            fifo_d_q <= {dc_q, db_q};
         end
         if (acc_end && dir_q && dc_q) begin
            disp_rd_pulse_out <= 1'b1;
         end
         // A serial frame cut short by deselect is dropped, never pushed.
         if (!sel || ps_q) begin
            shift_q <= `LCDHBI_DATA_RST;
            bitcnt_q <= 3'h0;
         end else if (sclk_rise) begin
            // Eight rising shift-clock edges make a byte, first bit most significant.
            shift_q <= {shift_q[6:0], d7_q};
            bitcnt_q <= bitcnt_q + 3'h1;
            if (bitcnt_q == `LCDHBI_BITCNT_LAST) begin
               fifo_v_q <= 1'b1;
               fifo_d_q <= {dc_q, shift_q[6:0], d7_q};
            end
         end
         // Overflow stays set until reset so that a lost byte is never missed.
         if (fifo_v_q && !fifo_rdy) begin
            overflow_out <= 1'b1;
         end
         // Read data goes out only in parallel mode during a selected read.
         if (par_on && par_read) begin
            data_pins_oe_n_out <= 8'h00;
            data_pins_out <= dc_q ? disp_rd_data_in : status_in;
         end else begin
            data_pins_oe_n_out <= `LCDHBI_BUS_IDLE;
         end
      end
   end
   // The buffer absorbs bursts while the consumer stalls.
   lcdhbi_fifo #(
      .WIDTH(9),
      .DEPTH(`LCDHBI_FIFO_DEPTH),
      .AW(`LCDHBI_FIFO_AW)
   ) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(fifo_v_q),
      .in_ready_out(fifo_rdy),
      .in_data_in(fifo_d_q),
      .out_valid_out(fifo_ov),
      .out_ready_in(rx_take),
      .out_data_out(fifo_od)
   );
   // Output register of the received-byte stream; it holds while stalled.
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         rx_valid_out <= 1'b0;
         rx_data_out <= `LCDHBI_DATA_RST;
         rx_is_display_out <= 1'b0;
      end else if (rx_take) begin
         rx_valid_out <= fifo_ov;
         if (fifo_ov) begin
            rx_data_out <= fifo_od[7:0];
            rx_is_display_out <= fifo_od[8];
         end
      end
   end
endmodule // lcdhbi_host_if

//--- lcdhbi_host_model.sv
`timescale 1ns/1ps
module lcdhbi_host_model (
   input wire clk_in,
   input wire s68_in,
   input wire [7:0] bus_in,
   output logic cs_n_out = 1'b1, dc_out = 1'b0, rd_out = 1'b1, wr_out = 1'b1,
   output logic [7:0] drv_out = 8'h00
);
   // A read leaves the bus to the device; the host's own lines show a changing pattern.
   task automatic acc(input logic rnw, a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      dc_out <= a;
      drv_out <= rnw ? ~drv_out : d;
      rd_out <= s68_in | ~rnw;
      wr_out <= rnw;
      repeat (10) @(posedge clk_in);
      q = bus_in;
      rd_out <= ~s68_in;
      wr_out <= 1'b1;
      repeat (6) @(posedge clk_in);
      cs_n_out <= 1'b1;
      drv_out <= ~drv_out;
      repeat (4) @(posedge clk_in);
   endtask
   // The shift clock rests low between frames; n below 8 sends a cut-short frame.
   task automatic ser(input logic a, input logic [7:0] d, input int n);
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      dc_out <= a;
      for (int i = 7; i > 7 - n; i--) begin
         drv_out <= {d[i], 1'b0, ~drv_out[5:0]};
         repeat (4) @(posedge clk_in);
         drv_out[6] <= 1'b1;
         repeat (4) @(posedge clk_in);
      end
      drv_out[6] <= 1'b0;
      repeat (4) @(posedge clk_in);
      cs_n_out <= 1'b1;
      repeat (4) @(posedge clk_in);
   endtask
endmodule // lcdhbi_host_model

//--- lcdhbi_host_if_properties.sv
`timescale 1ns/1ps
module lcdhbi_host_if_properties (
   input wire clk_in, rst_n_in, parallel_strap_in, bus_style_strap_in,
   input wire chip_select_n_in, data_command_select_in, rd_pin_in, wr_pin_in,
   input wire [7:0] data_pins_in, data_pins_out, data_pins_oe_n_out,
   input wire [7:0] disp_rd_data_in, status_in, rx_data_out,
   input wire rx_valid_out, rx_ready_in, rx_is_display_out, disp_rd_pulse_out, overflow_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   wire sel80 = parallel_strap_in && !bus_style_strap_in && !chip_select_n_in;
   wire rd80 = sel80 && !rd_pin_in && wr_pin_in;
   wire wr80 = sel80 && rd_pin_in && !wr_pin_in;
   wire rds = rd80 && !data_command_select_in;
   wire rdd = rd80 && data_command_select_in;
   a_serial_no_drive:
      assert property (!parallel_strap_in [*8] |-> data_pins_oe_n_out == 8'hFF)
      else $error("serial mode drove the bus");
   a_desel_float:
      assert property (chip_select_n_in [*8] ##1 chip_select_n_in [*4] |-> &data_pins_oe_n_out)
      else $error("bus driven while deselected");
   a_read_drives:
      assert property (rd80 [*8] ##1 rd80 |-> data_pins_oe_n_out == 8'h00)
      else $error("read did not drive the bus");
   a_write_float:
      assert property (wr80 [*8] ##1 wr80 |-> data_pins_oe_n_out == 8'hFF)
      else $error("bus driven during a write");
   a_status_value:
      assert property (rds [*8] ##1 rds |-> data_pins_out == status_in)
      else $error("status read returned wrong byte");
   a_disp_value:
      assert property (rdd [*8] ##1 rdd |-> data_pins_out == disp_rd_data_in)
      else $error("display read returned wrong byte");
   a_rx_hold_stall:
      assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out)
         && $stable(rx_is_display_out)) else $error("received byte changed while stalled");
   a_overflow_sticky:
      assert property (overflow_out |=> overflow_out) else $error("overflow flag dropped");
   a_reset_idle:
      assert property (disable iff (1'b0) !rst_n_in |=> &data_pins_oe_n_out && !rx_valid_out)
      else $error("outputs not idle after reset");
   c_disp_rx: cover property (rx_valid_out && rx_is_display_out);
   c_disp_pulse: cover property (disp_rd_pulse_out);
   c_overflow: cover property (overflow_out);
endmodule // lcdhbi_host_if_properties
bind lcdhbi_host_if lcdhbi_host_if_properties u_props (.*);

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic clk_in = 1'b0, rst_n_in = 1'b0, parallel_strap_in = 1'b1;
   logic bus_style_strap_in = 1'b0, rx_ready_in = 1'b0;
   logic [7:0] disp_rd_data_in = 8'hC3, status_in = 8'h5A, q, pulses = 8'h00;
   wire chip_select_n_in, data_command_select_in, rd_pin_in, wr_pin_in;
   wire [7:0] data_pins_in, data_pins_out, data_pins_oe_n_out, rx_data_out, drv;
   wire rx_valid_out, rx_is_display_out, disp_rd_pulse_out, overflow_out;
   int miscompares = 0, comparisons = 0, cycles = 0;
   assign data_pins_in = (data_pins_out & ~data_pins_oe_n_out) | (drv & data_pins_oe_n_out);
   lcdhbi_host_if u_lcdhbi_host_if (.*);
   lcdhbi_host_model u_lcdhbi_host_model (.clk_in(clk_in), .s68_in(bus_style_strap_in),
      .bus_in(data_pins_in), .cs_n_out(chip_select_n_in), .dc_out(data_command_select_in),
      .rd_out(rd_pin_in), .wr_out(wr_pin_in), .drv_out(drv));
   always #10 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (disp_rd_pulse_out === 1'b1) pulses <= pulses + 8'h01;
      if (cycles == 20000) begin miscompares++; complete_run(); end
   end
   task complete_run;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [7:0] s, e);
      comparisons++;
      if (s !== e) begin miscompares++; $display("BAD %0t got %h exp %h", $time, s, e); end
   endtask
   task get(input logic [7:0] d, input logic a);
      int n;
      n = 0;
      @(negedge clk_in);
      while (rx_valid_out !== 1'b1 && n < 60) begin @(negedge clk_in); n++; end
      chk(rx_data_out, d);
      chk(rx_is_display_out, a);
      @(posedge clk_in) rx_ready_in <= 1'b1;
      @(posedge clk_in) rx_ready_in <= 1'b0;
   endtask
   task t_par80;
      u_lcdhbi_host_model.acc(1'b0, 1'b1, 8'hA5, q);
      get(8'hA5, 1'b1);
      u_lcdhbi_host_model.acc(1'b0, 1'b0, 8'h3C, q);
      get(8'h3C, 1'b0);
      u_lcdhbi_host_model.acc(1'b1, 1'b0, 8'h00, q);
      chk(q, 8'h5A);
      u_lcdhbi_host_model.acc(1'b1, 1'b1, 8'h00, q);
      chk(q, 8'hC3);
      repeat (8) @(negedge clk_in);
      chk(pulses, 8'h01);
   endtask
   task t_68;
      bus_style_strap_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      u_lcdhbi_host_model.acc(1'b0, 1'b1, 8'h96, q);
      get(8'h96, 1'b1);
      u_lcdhbi_host_model.acc(1'b1, 1'b0, 8'h00, q);
      chk(q, 8'h5A);
      bus_style_strap_in <= 1'b0;
   endtask
   task t_ser;
      parallel_strap_in <= 1'b0;
      repeat (8) @(posedge clk_in);
      u_lcdhbi_host_model.ser(1'b0, 8'hE1, 5);
      u_lcdhbi_host_model.ser(1'b1, 8'h81, 8);
      get(8'h81, 1'b1);
      u_lcdhbi_host_model.ser(1'b0, 8'h42, 8);
      get(8'h42, 1'b0);
      u_lcdhbi_host_model.acc(1'b1, 1'b0, 8'h00, q);
      chk(q, ~drv);
      chk(rx_valid_out, 1'b0);
      parallel_strap_in <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask
   task t_fifo;
      for (int i = 0; i < 12; i++) u_lcdhbi_host_model.acc(1'b0, 1'b1, 8'h10 + i, q);
      chk(overflow_out, 1'b1);
      for (int i = 0; i < 8; i++) get(8'h10 + i, 1'b1);
   endtask
   initial begin
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      t_par80();
      t_68();
      t_ser();
      t_fifo();
      complete_run();
   end
endmodule // tb_top
